// [dma_channel_register_set.sv]
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`include "dma_regs_map.svh"
`default_nettype none
module dma_channel_register_set
    import dma_regs_pkg::*;
#(
    parameter int CHANNELS = 8
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [CHANNELS-1:0] done_event,
    output logic [CHANNELS-1:0] queue_flush,
    output logic [CHANNELS-1:0] ext_request_allowed,
    output logic [CHANNELS-1:0] request_sense_select,
    output logic [CHANNELS-1:0] accept_polarity,
    output logic [CHANNELS-1:0] ack_phase_select,
    output logic [CHANNELS-1:0] ack_polarity,
    output logic [CHANNELS-1:0] ack_every_cycle,
    output logic [CHANNELS*2-1:0] dst_addr_step,
    output logic [CHANNELS*2-1:0] src_addr_step,
    output logic [CHANNELS*3-1:0] src_space_attr,
    output logic [CHANNELS*3-1:0] dst_space_attr,
    output logic [CHANNELS-1:0] src_wait_sel,
    output logic [CHANNELS-1:0] dst_wait_sel,
    output logic [CHANNELS*4-1:0] request_source,
    output logic [CHANNELS-1:0] bus_cycle_style,
    output logic [CHANNELS*3-1:0] unit_size,
    output logic [CHANNELS-1:0] channel_enable,
    output logic [CHANNELS-1:0] done_irq_enable,
    output logic [CHANNELS-1:0] done_flag
);

    logic [31:0] src_address [CHANNELS];
    logic [31:0] dst_address [CHANNELS];
    logic [31:0] transfer_count [CHANNELS];
    logic [31:0] channel_control [CHANNELS];
    logic [31:0] opreg;
    logic [1:0] single_mode [CHANNELS];
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;

    // channel slots sit at 0x00..0x3c and 0x50..0x8c, opreg gap at 0x40
    function automatic logic [3:0] chan_of(input logic [7:0] a);
        logic [7:0] b;
        b = (a >= 8'h50) ? a - 8'h10 : a;
        return {1'b0, b[6:4]};
    endfunction : chan_of

    function automatic logic is_chan(input logic [7:0] a);
        return (a < 8'h40) || (a >= 8'h50 && a < 8'h90);
    endfunction : is_chan

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [7:0] wa = aw_take ? s_axi_awaddr : aw_addr;
    wire [31:0] wd = w_take ? s_axi_wdata : w_data;
    wire [3:0] ws = w_take ? s_axi_wstrb : w_strb;
    wire have_aw = aw_take || aw_held;
    wire have_w = w_take || w_held;
    wire do_write = have_aw && have_w;
    // control registers accept full-word writes only
    wire full_word = (ws == 4'hf);
    wire w_chan_ok = is_chan(wa) && (wa[1:0] == 2'b00) && full_word;
    wire w_op_ok = (wa == `ADDR_OPREG) && full_word;
    wire w_sm_ok = (wa == `ADDR_SINGLE_MODE) && full_word;
    wire w_ok = w_chan_ok || w_op_ok || w_sm_ok;
    wire [3:0] w_ch = chan_of(wa);
    wire [1:0] w_reg = wa[3:2];
    wire on_demand = opreg[`OPREG_ON_DEMAND];
    wire eight_ch = opreg[`OPREG_CH_COUNT];

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else
        begin
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_ok ? 2'b00 : 2'b10;
            end
            else
            begin
                if (aw_take)
                begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (w_take)
                begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            opreg <= 32'h00000000;
        end
        else if (do_write && w_op_ok)
        begin
            opreg <= wd & `OPREG_MASK;
        end
    end

    // per-channel storage; control state survives low-power modes untouched
    for (genvar c = 0; c < CHANNELS; c++)
    begin : g_ch
        wire hit = do_write && w_chan_ok && (w_ch == 4'(c));
        wire [31:0] ch_mask = (c < 2) ? `CTL_MASK :
            (`CTL_MASK & ~(32'h1 << `CTL_ACC_POL) & ~(32'h1 << `CTL_ACK_POL));
        wire ctl_hit = hit && (w_reg == `OFF_CTL);
        // done flag: write 0 clears, write 1 keeps; a new event wins
        wire next_done = done_event[c] ||
            (channel_control[c][`CTL_DONE] && !(ctl_hit && !wd[`CTL_DONE]));

        always_ff @(posedge ref_clk)
        begin
            if (hit && w_reg == `OFF_SRC)
                src_address[c] <= wd;
        end

        always_ff @(posedge ref_clk)
        begin
            if (hit && w_reg == `OFF_DST)
                dst_address[c] <= wd;
        end

        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
                transfer_count[c] <= 32'h00000000;
            else if (hit && w_reg == `OFF_CNT)
                transfer_count[c] <= wd & `CNT_MASK;
        end

        // reset to zero, no low-power clear
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
                channel_control[c] <= `CTL_RESET;
            else if (ctl_hit)
                channel_control[c] <= ((wd & ch_mask) & ~(32'h1 << `CTL_DONE))
                    | (32'(next_done) << `CTL_DONE);
            else
                channel_control[c][`CTL_DONE] <= next_done;
        end

        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
                single_mode[c] <= 2'b00;
            else if (do_write && w_sm_ok)
                single_mode[c] <= wd[2*c +: 2];
        end

        // flush only in on-demand eight-channel mode
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
                queue_flush[c] <= 1'b0;
            else
                queue_flush[c] <= ctl_hit && wd[`CTL_FLUSH] && on_demand && eight_ch;
        end

        wire [31:0] cc = channel_control[c];
        wire normal_ok = (c < 2) && !on_demand;
        // channels 4-7 refuse in four-channel on-demand
        assign ext_request_allowed[c] = on_demand ? (eight_ch || c < 4) : (c < 2);
        assign request_sense_select[c] = cc[`CTL_SENSE] && (normal_ok || on_demand);
        assign accept_polarity[c] = cc[`CTL_ACC_POL] && normal_ok;
        // ack phase validity, single address always acks
        assign ack_phase_select[c] = cc[`CTL_ACK_PHASE] && (normal_ok || (on_demand && c >= 1));
        assign ack_every_cycle[c] = (single_mode[c] != 2'b00);
        assign ack_polarity[c] = cc[`CTL_ACK_POL] && normal_ok;
        // destination step ignored memory to device
        assign dst_addr_step[2*c +: 2] =
            (single_mode[c] == 2'(single_mem_to_dev)) ? 2'b00 : cc[15:14];
        // source step ignored device to memory
        assign src_addr_step[2*c +: 2] =
            (single_mode[c] == 2'(single_dev_to_mem)) ? 2'b00 : cc[13:12];
        assign src_space_attr[3*c +: 3] = cc[31:29];
        assign dst_space_attr[3*c +: 3] = cc[27:25];
        assign src_wait_sel[c] = cc[28];
        assign dst_wait_sel[c] = cc[24];
        assign request_source[4*c +: 4] = cc[11:8];
        assign bus_cycle_style[c] = cc[7];
        assign unit_size[3*c +: 3] = cc[6:4];
        assign done_irq_enable[c] = cc[2];
        assign done_flag[c] = cc[1];
        assign channel_enable[c] = cc[0];
    end

    logic [31:0] sm_word;
    always_comb
    begin
        sm_word = 32'h00000000;
        for (int c = 0; c < CHANNELS; c++)
            sm_word[2*c +: 2] = single_mode[c];
    end

    wire [3:0] r_ch = chan_of(s_axi_araddr);
    wire r_chan = is_chan(s_axi_araddr) && (s_axi_araddr[1:0] == 2'b00);
    wire [31:0] r_word = (s_axi_araddr[3:2] == `OFF_SRC) ? src_address[r_ch[2:0]] :
        (s_axi_araddr[3:2] == `OFF_DST) ? dst_address[r_ch[2:0]] :
        (s_axi_araddr[3:2] == `OFF_CNT) ? transfer_count[r_ch[2:0]] :
        channel_control[r_ch[2:0]];
    wire r_op = (s_axi_araddr == `ADDR_OPREG);
    wire r_sm = (s_axi_araddr == `ADDR_SINGLE_MODE);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= r_chan ? r_word : r_op ? opreg : r_sm ? sm_word : 32'h00000000;
            s_axi_rresp <= (r_chan || r_op || r_sm) ? 2'b00 : 2'b10;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    AST_CNT_TOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        transfer_count[0][31:24] == 8'h00 && transfer_count[3][31:24] == 8'h00 &&
        transfer_count[7][31:24] == 8'h00)
        else $error("count upper bits nonzero");
    AST_DEAD_BITS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        channel_control[2][18] == 1'b0 && channel_control[2][16] == 1'b0 &&
        channel_control[5][18] == 1'b0 && channel_control[5][16] == 1'b0)
        else $error("dead bits set on upper channel");
    AST_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        channel_control[1][23:20] == 4'h0)
        else $error("reserved control bits set");
    // reserved bits zero on an upper channel
    AST_RSVD_HI: assert property (@(posedge ref_clk) disable iff (!rst_n)
        channel_control[5][23:20] == 4'h0)
        else $error("reserved control bits set on channel 5");
    AST_FLUSH_RD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        channel_control[0][`CTL_FLUSH] == 1'b0)
        else $error("flush bit read back as one");
    AST_FLUSH_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (queue_flush != '0) |-> $past(on_demand) && $past(eight_ch))
        else $error("flush outside eight-channel on-demand");
    AST_FLUSH_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (queue_flush != '0) |=> (queue_flush == '0))
        else $error("flush pulse longer than one cycle");
    AST_ACC_POL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        on_demand |-> accept_polarity[0] == 1'b0)
        else $error("accept polarity active in on-demand");
    // accept polarity never on channels 2-7
    AST_ACC_POL_HI: assert property (@(posedge ref_clk) disable iff (!rst_n)
        accept_polarity[7:2] == 6'h00)
        else $error("accept polarity active on upper channel");
    AST_ACK_POL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        on_demand |-> ack_polarity[1] == 1'b0)
        else $error("ack polarity active in on-demand");
    // ack polarity never on channels 2-7
    AST_ACK_POL_HI: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ack_polarity[7:2] == 6'h00)
        else $error("ack polarity active on upper channel");
    // channel 0 ack phase dead in on-demand
    AST_ACK_PHASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        on_demand |-> ack_phase_select[0] == 1'b0)
        else $error("ch0 ack phase active in on-demand");
    // ack phase limited to ch0-1 in normal mode
    AST_ACK_PHASE_NORMAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !on_demand |-> ack_phase_select[7:2] == 6'h00)
        else $error("upper ack phase active in normal mode");
    // ack phase honoured on channel 5 in on-demand
    AST_DEMAND_ACK_PHASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        on_demand |-> ack_phase_select[5] == channel_control[5][`CTL_ACK_PHASE])
        else $error("ch5 ack phase lost in on-demand");
    AST_ACK_ALWAYS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        single_mode[1] != 2'b00 |-> ack_every_cycle[1])
        else $error("single address transfer without ack");
    // request sense limited to ch0-1 in normal mode
    AST_SENSE_NORMAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !on_demand |-> request_sense_select[7:2] == 6'h00)
        else $error("upper request sense active in normal mode");
    // request sense honoured on channel 5 in on-demand
    AST_DEMAND_SENSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        on_demand |-> request_sense_select[5] == channel_control[5][`CTL_SENSE])
        else $error("ch5 request sense lost in on-demand");
    AST_CH_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (on_demand && !eight_ch) |-> ext_request_allowed[7:4] == 4'h0)
        else $error("upper channel accepts in four-channel mode");
    // normal mode takes requests on ch0-1 only
    AST_COUNT_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !on_demand |-> ext_request_allowed == 8'h03)
        else $error("wrong request channels in normal mode");
    AST_DST_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        single_mode[1] == 2'(single_mem_to_dev) |-> dst_addr_step[3:2] == 2'b00)
        else $error("dst step not ignored");
    AST_SRC_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        single_mode[1] == 2'(single_dev_to_mem) |-> src_addr_step[3:2] == 2'b00)
        else $error("src step not ignored");
    // control cleared while reset is held
    AST_CTL_RESET: assert property (@(posedge ref_clk)
        !rst_n |-> channel_control[1] == `CTL_RESET && channel_control[5] == `CTL_RESET)
        else $error("control register not cleared by reset");

endmodule : dma_channel_register_set
`default_nettype wire

// [dma_regs_map.svh]
// How it works
// - each channel has a 32-bit read/write source address register.
// - each channel has a 32-bit read/write destination address register.
// - count bits 23:0 writable in transfer units; bits 31:24 read zero.
// - control registers clear to zero on power-on or manual reset.
// - control registers keep their contents in low-power states.
// - attribute nibbles act only for PCMCIA area 5/6 transfers, else kept zero.
// - three-bit space attribute fields drive the PCMCIA access attribute.
// - wait-select bits 28 and 24 pick the area 5/6 wait register.
// - channels 2 to 7 ignore bits 18 and 16 and read them zero.
// - control bits 23:20 reserved, read zero.
// - bit 19 request sense valid on ch0-1 normal, all channels on-demand.
// - bit 18 accept polarity valid on ch0-1 normal only.
// - bit 17 ack phase valid ch0-1 normal, ch1-7 on-demand; single always acks.
// - bit 16 ack polarity valid on ch0-1 normal only.
// - destination step ignored for single address memory-to-device transfers.
// - source step ignored for single address device-to-memory transfers.
// - request source 11:8, bus mode bit 7, unit size 6:4.
// - writing one to bit 3 flushes the queue in on-demand eight-channel mode.
// - flush bit reads zero; writing zero does nothing.
// - operation register bit 14 picks four or eight on-demand request channels.
`ifndef DMA_REGS_MAP_SVH
`define DMA_REGS_MAP_SVH
`define OFF_SRC 2'd0
`define OFF_DST 2'd1
`define OFF_CNT 2'd2
`define OFF_CTL 2'd3
`define ADDR_OPREG 8'h40
`define ADDR_SINGLE_MODE 8'h90
`define OPREG_ON_DEMAND 15
`define OPREG_CH_COUNT 14
`define CNT_MASK 32'h00ffffff
`define CTL_MASK 32'hff0ffff7
`define CTL_RESET 32'h00000000
`define CTL_FLUSH 3
`define CTL_SENSE 19
`define CTL_ACC_POL 18
`define CTL_ACK_PHASE 17
`define CTL_ACK_POL 16
`define CTL_DONE 1
`define OPREG_MASK 32'h0000c301
`endif

// [dma_regs_pkg.sv]
`default_nettype none
package dma_regs_pkg;
    typedef enum logic [1:0] {
        single_none,
        single_mem_to_dev,
        single_dev_to_mem
    } single_dir_t;
endpackage : dma_regs_pkg
`default_nettype wire

// [dma_done_source.sv]
`default_nettype none
module dma_done_source
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] fire,
    input wire logic [3:0] lag,
    output logic [7:0] done_event
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pend;
    logic [3:0] count;
    // a finish is only reported after the transfer had time to run
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend <= 8'h00;
            count <= 4'h0;
            done_event <= 8'h00;
        end
        else if (fire != 8'h00)
        begin
            pend <= fire;
            count <= lag;
            done_event <= 8'h00;
        end
        else if (pend != 8'h00 && count == 4'h0)
        begin
            done_event <= pend;
            pend <= 8'h00;
        end
        else
        begin
            done_event <= 8'h00;
            if (count != 4'h0)
                count <= count - 4'h1;
        end
    end
endmodule : dma_done_source
`default_nettype wire

// [test_dma_channel_register_set.sv]
`default_nettype none
module test_dma_channel_register_set;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} row_t;
    logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, fire, flush_last;
    logic [31:0] s_axi_wdata, s_axi_rdata, request_source, rd;
    logic [3:0] s_axi_wstrb, lag;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] done_event, queue_flush, ext_request_allowed, request_sense_select;
    logic [7:0] accept_polarity, ack_phase_select, ack_polarity, ack_every_cycle, src_wait_sel;
    logic [7:0] dst_wait_sel, bus_cycle_style, channel_enable, done_irq_enable, done_flag;
    logic [15:0] dst_addr_step, src_addr_step;
    logic [23:0] src_space_attr, dst_space_attr, unit_size;
    int n_fail, total_checks, flush_seen, i;
    row_t rows[6] = '{'{8'h00, 32'h12345678, 32'h12345678}, '{8'h84, 32'hdeadbeef, 32'hdeadbeef},
        '{8'h38, 32'hffffffff, 32'h00ffffff}, '{8'h0c, 32'hffffffff, 32'hff0ffff5},
        '{8'h1c, 32'hb4f3a5dc, 32'hb403a5d4}, '{8'h6c, 32'hffffffff, 32'hff0afff5}};
    dma_channel_register_set dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .done_event, .queue_flush,
        .ext_request_allowed, .request_sense_select, .accept_polarity, .ack_phase_select,
        .ack_polarity, .ack_every_cycle, .dst_addr_step, .src_addr_step, .src_space_attr,
        .dst_space_attr, .src_wait_sel, .dst_wait_sel, .request_source, .bus_cycle_style,
        .unit_size, .channel_enable, .done_irq_enable, .done_flag);
    dma_done_source far_end (.ref_clk, .rst_n, .fire, .lag, .done_event);
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk)
        if (queue_flush !== 8'h00)
        begin
            flush_seen++;
            flush_last = queue_flush;
        end
    task automatic close_out();
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s got %h want %h", $time, msg, got, exp);
            n_fail++;
        end
    endtask : check
    task automatic give_up();
        $display("[FAIL] %0t no answer", $time);
        n_fail++;
        close_out();
    endtask : give_up
    // both channels offered at once; each released once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic aw, w, b;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(negedge ref_clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge ref_clk);
            if (aw)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
            if (b)
            begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 100)
            give_up();
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a);
        int n;
        logic ar, r;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(negedge ref_clk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge ref_clk);
            if (ar)
                s_axi_arvalid <= 1'b0;
            if (r)
            begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 100)
            give_up();
    endtask : axi_read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d, 4'hf);
    endtask : wr
    initial
    begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, fire, lag} = '0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++)
        begin
            wr(rows[i].a, rows[i].w);
            axi_read(rows[i].a);
            check(rd, rows[i].r, "readback");
        end
        check(flush_seen, 0, "flush in normal mode");
        check(ext_request_allowed, 8'h03, "normal requests");
        check({request_sense_select[5], accept_polarity[5], ack_phase_select[5], ack_polarity[5],
            request_sense_select[0], accept_polarity[0], ack_phase_select[0], ack_polarity[0]},
            8'h0f, "normal validity");
        check({src_space_attr[5:3], src_wait_sel[1], dst_space_attr[5:3], dst_wait_sel[1],
            request_source[7:4], bus_cycle_style[1], unit_size[5:3], done_irq_enable[1],
            channel_enable[1], ack_phase_select[1], ack_polarity[1], dst_addr_step[3:2],
            src_addr_step[3:2], ack_every_cycle[1]}, 25'h168bb74, "fields");
        wr(8'h90, 32'h4);
        check({dst_addr_step[3:2], src_addr_step[3:2], ack_every_cycle[1]}, 5'h05, "m2d");
        wr(8'h90, 32'h8);
        check({dst_addr_step[3:2], src_addr_step[3:2], ack_every_cycle[1]}, 5'h11, "d2m");
        wr(8'h40, 32'h8000);
        check(ext_request_allowed, 8'h0f, "four demand channels");
        check({request_sense_select[5], accept_polarity[5], ack_phase_select[5], ack_polarity[5],
            request_sense_select[0], accept_polarity[0], ack_phase_select[0], ack_polarity[0]},
            8'ha8, "demand validity");
        wr(8'h6c, 32'h8);
        check(flush_seen, 0, "flush with four channels");
        wr(8'h40, 32'hffffffff);
        axi_read(8'h40);
        check(rd, 32'h0000c301, "operation reg");
        check(ext_request_allowed, 8'hff, "eight demand channels");
        wr(8'h6c, 32'h8);
        axi_read(8'h6c);
        check(rd, 32'h0, "flush bit reads zero");
        check(flush_seen, 1, "one flush pulse");
        check(flush_last, 8'h20, "flush channel");
        fire <= 8'h02;
        lag <= 4'h4;
        @(posedge ref_clk);
        fire <= 8'h00;
        for (i = 0; i < 50 && done_flag[1] !== 1'b1; i++)
            @(negedge ref_clk);
        if (i == 50)
            give_up();
        axi_read(8'h1c);
        check(rd, 32'hb403a5d6, "done flag set");
        wr(8'h1c, 32'hb403a5d4);
        check(done_flag, 8'h00, "done flag cleared");
        axi_write(8'h00, 32'h0, 4'h3);
        check(resp, 2'b10, "narrow write");
        axi_read(8'h00);
        check(rd, 32'h12345678, "narrow write kept");
        axi_read(8'h94);
        check(resp, 2'b10, "unmapped read resp");
        check(rd, 32'h0, "unmapped read data");
        axi_write(8'h94, 32'h1, 4'hf);
        check(resp, 2'b10, "unmapped write");
        axi_read(8'h0e);
        check(resp, 2'b10, "misaligned read");
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        axi_read(8'h1c);
        check(rd, 32'h0, "control after reset");
        check({channel_enable, ext_request_allowed}, 16'h0003, "outputs after reset");
        close_out();
    end
endmodule : test_dma_channel_register_set
`default_nettype wire
